// ---- rtl/dph_pkg.sv ----
// Shared constants and types of the peripheral hub DMA engine
package dph_pkg;
   localparam int          NUM_CH       = 24;
   localparam int          NUM_TD       = 128;
   localparam int          CH_W         = 5;
   localparam int          TD_W         = 7;
   localparam int          LVL_N        = 8;
   localparam int          SLOT_W       = 6;
   localparam int          FIFO_DEPTH   = 8;
   localparam logic [2:0]  CPU_MAX_WINS = 3'h4;
   localparam logic [2:0]  FAIR_LVL0    = 3'h2;
   localparam logic [7:0]  TOP_LVL_MASK = 8'h03;
   localparam logic [2:0]  TD_SPOKE     = 3'h2;
   localparam int          SPK_MSB      = 31;
   localparam int          SPK_LSB      = 29;
   localparam int          TD_SEL       = 28;
   localparam int          WRD_MSB      = 10;
   localparam int          WRD_LSB      = 2;
   localparam int          WORD_BITS    = 32;
   localparam logic [4:0]  BOOT_CH      = 5'h00;

   typedef enum logic {RS_IDLE = 1'b0, RS_READ = 1'b1} dph_rd_t;

   // Descriptor, four words: src, dst, length/link/control, upper trigger channel bits and reserved
   typedef struct packed {
      logic [27:0]     rsvd;
      logic [CH_W-1:0] trig_ch;
      logic            trig_en;
      logic            irq_en;
      logic [1:0]      size_m1;
      logic            dst_inc;
      logic            src_inc;
      logic            infinite;
      logic            chain;
      logic [TD_W-1:0] next_td;
      logic [15:0]     len_m1;
      logic [31:0]     dst;
      logic [31:0]     src;
   } dph_td_t;

   typedef struct packed {
      logic            active;
      logic [TD_W-1:0] td;
      logic [16:0]     rem;
      logic [15:0]     ofs;
   } dph_chan_t;

   typedef struct packed {
      logic [31:0] addr;
      logic [1:0]  size_m1;
      logic [31:0] data;
   } dph_cmd_t;

   typedef struct packed {
      dph_cmd_t        cmd;
      logic [CH_W-1:0] ch;
      logic            td_last;
      logic            chain_last;
      logic            irq;
      logic            trig_en;
      logic [CH_W-1:0] trig_ch;
   } dph_ent_t;
endpackage

// ---- rtl/dph_hub.sv ----
// Peripheral hub DMA engine with fair priority arbiter and data FIFO
//
// What this block does
// - CPU and DMA are both bus initiators
// - CPU and DMA run together on different spokes
// - Source and destination bursts overlap across spokes
// - Transfers of 8, 16, 24, 32 bits
// - 24 channels share 128 descriptors
// - Descriptors rewritable at run time
// - Eight levels, smaller number wins
// - Trigger by routed signal, CPU, channel
// - Two interrupts per channel per transfer
// - Active channel can be stalled or cancelled
// - Length 1 to 64k bytes, or endless
// - Descriptors chain and may rewrite others
// - CPU first on conflict, never starving DMA
// - Preemption only at transaction boundaries
// - Fair shares for levels 2 to 7
// - Levels 0 and 1 outside fairness
// - Equal levels alternate round robin
// - Per-channel opt-out wins ties at level
// - Fairness off means strict priority
// - One descriptor moves source to destination
// - Self-linked descriptor repeats forever
// - Boot configuration transfers run through hub
// - Mutually linked descriptors give double buffering
`timescale 1ns/10ps

// ************************************
// Data FIFO between read and write side
// ************************************
module dph_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic             core_clk,
   input  wire logic             reset,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wp;
      logic [AW-1:0]               rp;
      logic [AW:0]                 cnt;
   } dph_fifo_st_t;
   dph_fifo_st_t st;
   dph_fifo_st_t next_st;
   logic         push;
   logic         pop;
   assign in_ready  = st.cnt != (AW+1)'(DEPTH);
   assign out_valid = st.cnt != '0;
   assign out_data  = st.mem[st.rp];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;
   always_comb begin
      next_st = st;
      if (push) begin
         next_st.mem[st.wp] = in_data;
         next_st.wp = (st.wp == AW'(DEPTH-1)) ? '0 : st.wp + 1'b1;
      end
      if (pop) next_st.rp = (st.rp == AW'(DEPTH-1)) ? '0 : st.rp + 1'b1;
      next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge core_clk) begin
      if (reset) st <= '0;
      else st <= next_st;
   end

   chk_fifo_fill: assert property (@(posedge core_clk) disable iff (reset)
      push && !pop |=> st.cnt == $past(st.cnt) + 1'b1) else $error("fifo count not advanced");
endmodule

// ************************************
// Hub top
// ************************************
module dph_hub
   import dph_pkg::*;
(
   input  wire logic                       core_clk,
   input  wire logic                       reset,
   input  wire logic                       fairness_en,
   input  wire logic                       boot_en,
   input  wire logic [NUM_CH-1:0]          ch_en,
   input  wire logic [NUM_CH-1:0]          ch_stall,
   input  wire logic [NUM_CH-1:0]          ch_cancel,
   input  wire logic [NUM_CH-1:0]          rr_disable,
   input  wire logic [NUM_CH-1:0][2:0]     ch_prio,
   input  wire logic [NUM_CH-1:0][TD_W-1:0] ch_first_td,
   input  wire logic [NUM_CH-1:0]          hw_trig,
   input  wire logic [NUM_CH-1:0]          cpu_trig,
   input  wire logic                       td_wr,
   input  wire logic [TD_W+1:0]            td_wr_word,
   input  wire logic [31:0]                td_wr_data,
   input  wire logic                       cpu_req,
   input  wire logic [31:0]                cpu_addr,
   output logic                            cpu_grant,
   output logic                            rd_req,
   output dph_cmd_t                        rd_cmd,
   input  wire logic                       rd_ack,
   input  wire logic [31:0]                rd_data,
   output logic                            wr_req,
   output dph_cmd_t                        wr_cmd,
   input  wire logic                       wr_ack,
   output logic [NUM_CH-1:0]               irq_done,
   output logic [NUM_CH-1:0]               irq_end,
   output logic [NUM_CH-1:0]               ch_active
);
   typedef struct packed {
      dph_td_t [NUM_TD-1:0]   pool;
      dph_chan_t [NUM_CH-1:0] ch;
      dph_rd_t                rd_st;
      dph_cmd_t               rd_cmd;
      logic [CH_W-1:0]        cur;
      logic [CH_W-1:0]        rr_ptr;
      logic [SLOT_W-1:0]      slot;
      logic [2:0]             cpu_wins;
      logic [NUM_CH-1:0]      irq_done;
      logic [NUM_CH-1:0]      irq_end;
      logic                   boot_done;
   } dph_st_t;
   dph_st_t           st;
   dph_st_t           next_st;
   logic [NUM_CH-1:0] pend;
   logic [NUM_CH-1:0] arm;
   logic [LVL_N-1:0]  lvl_req;
   logic [2:0]        best_lvl;
   logic [2:0]        rsv_lvl;
   logic [2:0]        sel_lvl;
   logic [CH_W-1:0]   gnt_ch;
   logic              gnt_ok;
   dph_ent_t          ent;
   dph_ent_t          head;
   logic              f_in_valid;
   logic              f_in_ready;
   logic              f_out_valid;
   logic              f_out_ready;
   logic              f_pop;
   logic              td_hit;
   logic              c_rd;
   logic              c_wr;
   logic              starve;

   // ************************************
   // Bus sharing with the CPU
   // ************************************
   assign td_hit = head.cmd.addr[SPK_MSB:SPK_LSB] == TD_SPOKE && head.cmd.addr[TD_SEL];
   assign c_rd   = st.rd_st == RS_READ && cpu_req && cpu_addr[SPK_MSB:SPK_LSB] == st.rd_cmd.addr[SPK_MSB:SPK_LSB];
   assign c_wr   = f_out_valid && !td_hit && cpu_req
                   && cpu_addr[SPK_MSB:SPK_LSB] == head.cmd.addr[SPK_MSB:SPK_LSB];
   assign starve = st.cpu_wins == CPU_MAX_WINS;
   assign cpu_grant = cpu_req && !(starve && (c_rd || c_wr));
   assign rd_req    = st.rd_st == RS_READ && !(c_rd && !starve);
   assign wr_req    = f_out_valid && !td_hit && !(c_wr && !starve);
   assign f_out_ready = td_hit || (wr_req && wr_ack);
   assign f_pop     = f_out_valid && f_out_ready;
   assign rd_cmd    = st.rd_cmd;
   assign wr_cmd    = head.cmd;
   assign irq_done  = st.irq_done;
   assign irq_end   = st.irq_end;

   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_act
         assign ch_active[g] = st.ch[g].active;
      end
   endgenerate

   dph_fifo #(
      .WIDTH ($bits(dph_ent_t)),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .core_clk  (core_clk),
      .reset     (reset),
      .in_valid  (f_in_valid),
      .in_ready  (f_in_ready),
      .in_data   (ent),
      .out_valid (f_out_valid),
      .out_ready (f_out_ready),
      .out_data  (head)
   );

   // ************************************
   // Arbiter, read engine, write side effects
   // ************************************
   always_comb begin
      dph_chan_t       cs;
      dph_td_t         td;
      logic [16:0]     step;
      logic            last;
      logic [CH_W-1:0] c5;
      logic            found;
      logic            found_fix;
      cs = '0;
      td = '0;
      step = '0;
      last = 1'b0;
      c5 = '0;
      found = 1'b0;
      found_fix = 1'b0;
      next_st = st;
      next_st.irq_done = '0;
      next_st.irq_end = '0;
      pend = '0;
      lvl_req = '0;
      ent = '0;
      f_in_valid = 1'b0;
      arm = hw_trig | cpu_trig;
      for (int c = 0; c < NUM_CH; c++) begin
         pend[c] = st.ch[c].active & ch_en[c] & ~ch_stall[c];
         if (pend[c]) lvl_req[ch_prio[c]] = 1'b1;
      end
      best_lvl = 3'(LVL_N-1);
      for (int l = LVL_N-1; l >= 0; l--) begin
         if (lvl_req[l]) best_lvl = 3'(l);
      end
      // Lowest set slot bit picks the reserved level: 1/2, 1/4, ...
      rsv_lvl = 3'(LVL_N-1);
      for (int b = SLOT_W-1; b >= 0; b--) begin
         if (st.slot[b]) rsv_lvl = FAIR_LVL0 + 3'(b);
      end
      sel_lvl = best_lvl;
      if (fairness_en && (lvl_req & TOP_LVL_MASK) == '0 && lvl_req[rsv_lvl]) sel_lvl = rsv_lvl;
      gnt_ch = '0;
      for (int i = 0; i < NUM_CH; i++) begin
         c5 = CH_W'((int'(st.rr_ptr) + 1 + i) % NUM_CH);
         if (pend[c5] && ch_prio[c5] == sel_lvl) begin
            if (rr_disable[c5] && !found_fix) begin
               gnt_ch = c5;
               found_fix = 1'b1;
               found = 1'b1;
            end else if (!found) begin
               gnt_ch = c5;
               found = 1'b1;
            end
         end
      end
      gnt_ok = found && st.rd_st == RS_IDLE && f_in_ready;
      if (starve && (!(c_rd || c_wr) || (c_rd && rd_ack) || (c_wr && wr_ack))) next_st.cpu_wins = '0;
      else if (!starve && (c_rd || c_wr)) next_st.cpu_wins = st.cpu_wins + 1'b1;
      if (boot_en && !st.boot_done) begin
         arm[BOOT_CH] = 1'b1;
         next_st.boot_done = 1'b1;
      end
      if (td_wr) begin
         next_st.pool[td_wr_word[TD_W+1:2]][int'(td_wr_word[1:0])*WORD_BITS +: WORD_BITS] = td_wr_data;
      end
      if (f_pop) begin
         if (td_hit) begin
            next_st.pool[head.cmd.addr[WRD_MSB:WRD_LSB+2]]
               [int'(head.cmd.addr[WRD_LSB+1:WRD_LSB])*WORD_BITS +: WORD_BITS] = head.cmd.data;
         end
         if (head.td_last && head.irq) next_st.irq_done[head.ch] = 1'b1;
         if (head.chain_last) next_st.irq_end[head.ch] = 1'b1;
         if (head.td_last && head.trig_en) arm[head.trig_ch] = 1'b1;
      end

      unique case (st.rd_st)
         RS_IDLE: begin
            if (gnt_ok) begin
               cs = st.ch[gnt_ch];
               td = st.pool[cs.td];
               next_st.rd_st = RS_READ;
               next_st.cur = gnt_ch;
               next_st.rr_ptr = gnt_ch;
               next_st.slot = st.slot + 1'b1;
               next_st.rd_cmd.addr = td.src + (td.src_inc ? 32'(cs.ofs) : 32'h0);
               next_st.rd_cmd.size_m1 = td.size_m1;
               next_st.rd_cmd.data = '0;
            end
         end
         RS_READ: begin
            if (rd_req && rd_ack) begin
               cs = st.ch[st.cur];
               td = st.pool[cs.td];
               step = 17'(td.size_m1) + 17'h1;
               last = !td.infinite && cs.rem <= step;
               ent.cmd.data = rd_data;
               ent.cmd.addr = td.dst + (td.dst_inc ? 32'(cs.ofs) : 32'h0);
               ent.cmd.size_m1 = td.size_m1;
               ent.ch = st.cur;
               ent.td_last = last;
               ent.chain_last = last && !td.chain;
               ent.irq = td.irq_en;
               ent.trig_en = td.trig_en;
               ent.trig_ch = td.trig_ch;
               f_in_valid = 1'b1;
               if (last && td.chain) begin
                  cs.td = td.next_td;
                  cs.rem = 17'(st.pool[td.next_td].len_m1) + 17'h1;
                  cs.ofs = '0;
               end else if (last) begin
                  cs.active = 1'b0;
               end else begin
                  if (!td.infinite) cs.rem = cs.rem - step;
                  cs.ofs = cs.ofs + step[15:0];
               end
               next_st.ch[st.cur] = cs;
               next_st.rd_st = RS_IDLE;
            end
         end
      endcase

      for (int c = 0; c < NUM_CH; c++) begin
         if (arm[c] && !st.ch[c].active) begin
            next_st.ch[c].active = 1'b1;
            next_st.ch[c].td = ch_first_td[c];
            next_st.ch[c].rem = 17'(st.pool[ch_first_td[c]].len_m1) + 17'h1;
            next_st.ch[c].ofs = '0;
         end
         if (ch_cancel[c]) next_st.ch[c].active = 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) st <= '0;
      else st <= next_st;
   end

   // ************************************
   // Checks
   // ************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   sequence s_grant;
      st.rd_st == RS_IDLE && next_st.rd_st == RS_READ;
   endsequence
   sequence s_done_pop;
      f_pop && head.td_last && head.irq;
   endsequence

   chk_cpu_first: assert property (
      cpu_req && (c_rd || c_wr) && !starve |-> cpu_grant && !(c_rd && rd_req) && !(c_wr && wr_req))
      else $error("cpu not first on shared spoke");
   chk_dma_served: assert property (
      starve && (c_rd || c_wr) |-> !cpu_grant && (!c_rd || rd_req) && (!c_wr || wr_req))
      else $error("dma starved by cpu");
   chk_dma_release: assert property (
      starve && ((c_rd && rd_ack) || (c_wr && wr_ack)) |=> st.cpu_wins == '0)
      else $error("cpu kept dma waiting after its turn");
   chk_spoke_share: assert property (
      cpu_grant && rd_req |-> cpu_addr[SPK_MSB:SPK_LSB] != rd_cmd.addr[SPK_MSB:SPK_LSB])
      else $error("cpu and dma on one spoke");
   chk_hold_cur: assert property (
      st.rd_st == RS_READ && !(rd_req && rd_ack) |=> st.rd_st == RS_READ && $stable(st.cur))
      else $error("transaction left before its end");
   chk_cancel_ch: assert property (
      ch_cancel != '0 |=> (ch_active & $past(ch_cancel)) == '0)
      else $error("cancelled channel still active");
   chk_stall_ch: assert property (
      s_grant |-> pend[gnt_ch] && !ch_stall[gnt_ch])
      else $error("stalled channel granted");
   chk_strict_lvl: assert property (
      s_grant and !fairness_en |-> ch_prio[gnt_ch] == best_lvl)
      else $error("strict priority broken");
   chk_top_lvl: assert property (
      s_grant and (lvl_req & TOP_LVL_MASK) != '0 |-> ch_prio[gnt_ch] < FAIR_LVL0)
      else $error("level 0 or 1 passed over");
   chk_irq_done: assert property (
      s_done_pop |=> irq_done[$past(head.ch)] ##1 !irq_done[$past(head.ch, 2)])
      else $error("done interrupt not one pulse");
endmodule

// ---- verification/dph_bus_model.sv ----
// Read and write bus slaves beyond the hub
`timescale 1ns/10ps
module dph_bus_model
   import dph_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        reset,
   input  wire logic        wr_hold,
   input  wire logic        rd_req,
   input  wire dph_cmd_t    rd_cmd,
   output logic             rd_ack,
   output logic [31:0]      rd_data,
   input  wire logic        wr_req,
   input  wire dph_cmd_t    wr_cmd,
   output logic             wr_ack
);
   logic [1:0] rd_cnt;
   logic [1:0] wr_cnt;
   logic       rd_slow;
   logic       wr_slow;

   // ****************
   // Slave responses
   // ****************
   // Answers alternate prompt and slow; data only valid with ack
   always_ff @(posedge core_clk) begin
      if (reset) begin
         rd_ack  <= 1'b0;
         wr_ack  <= 1'b0;
         rd_data <= 32'h0;
         rd_cnt  <= 2'h0;
         wr_cnt  <= 2'h0;
         rd_slow <= 1'b0;
         wr_slow <= 1'b0;
      end else begin
         rd_ack  <= 1'b0;
         wr_ack  <= 1'b0;
         rd_data <= ~rd_data;
         if (rd_req && !rd_ack) begin
            if (rd_cnt == 2'h0) begin
               rd_ack  <= 1'b1;
               rd_data <= {4{rd_cmd.addr[7:0] ^ 8'h5a}};
               rd_cnt  <= rd_slow ? 2'h0 : 2'h2;
               rd_slow <= !rd_slow;
            end else begin
               rd_cnt <= rd_cnt - 2'h1;
            end
         end
         if (wr_req && !wr_ack && !wr_hold) begin
            if (wr_cnt == 2'h0) begin
               wr_ack  <= 1'b1;
               wr_cnt  <= wr_slow ? 2'h0 : 2'h1;
               wr_slow <= !wr_slow;
            end else begin
               wr_cnt <= wr_cnt - 2'h1;
            end
         end
      end
   end
endmodule

// ---- verification/tb.sv ----
// Self-checking bench of the hub DMA engine
`timescale 1ns/10ps
module tb;
   import dph_pkg::*;
   logic                        core_clk, reset, fairness_en, boot_en, td_wr, cpu_req, cpu_grant;
   logic                        rd_req, rd_ack, wr_req, wr_ack, wr_hold;
   logic [NUM_CH-1:0]           ch_en, ch_stall, ch_cancel, rr_disable, hw_trig, cpu_trig;
   logic [NUM_CH-1:0]           irq_done, irq_end, ch_active;
   logic [NUM_CH-1:0][2:0]      ch_prio;
   logic [NUM_CH-1:0][TD_W-1:0] ch_first_td;
   logic [TD_W+1:0]             td_wr_word;
   logic [31:0]                 td_wr_data, cpu_addr, rd_data;
   dph_cmd_t                    rd_cmd, wr_cmd;
   logic [39:0]                 wq[$];
   int                          fail_count, compares, done_cnt, end_cnt;

   dph_hub dph_hub_inst (.core_clk, .reset, .fairness_en, .boot_en, .ch_en, .ch_stall, .ch_cancel,
      .rr_disable, .ch_prio, .ch_first_td, .hw_trig, .cpu_trig, .td_wr, .td_wr_word, .td_wr_data,
      .cpu_req, .cpu_addr, .cpu_grant, .rd_req, .rd_cmd, .rd_ack, .rd_data, .wr_req, .wr_cmd,
      .wr_ack, .irq_done, .irq_end, .ch_active);
   dph_bus_model dph_bus_model_inst (.core_clk, .reset, .wr_hold, .rd_req, .rd_cmd, .rd_ack,
      .rd_data, .wr_req, .wr_cmd, .wr_ack);

   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   always @(posedge core_clk) begin
      if (wr_req && wr_ack) wq.push_back({wr_cmd.addr, wr_cmd.data[7:0]});
      if (irq_done[1]) done_cnt++;
      if (irq_end[1]) end_cnt++;
   end

   // ****************
   // Shared tasks
   // ****************
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("compares=%0d fail_count=%0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   function automatic logic [31:0] ctl(input logic [15:0] len_m1, input logic [6:0] nxt,
                                       input logic chain, input logic irq);
      return {2'b00, irq, 2'b00, 2'b11, 1'b0, chain, nxt, len_m1};
   endfunction

   task automatic put_td(input int i, input logic [31:0] s, input logic [31:0] d,
                         input logic [31:0] w2);
      logic [31:0] w[4];
      w = '{s, d, w2, 32'h0};
      for (int k = 0; k < 4; k++) begin
         @(posedge core_clk);
         td_wr      <= 1'b1;
         td_wr_word <= {i[6:0], k[1:0]};
         td_wr_data <= w[k];
      end
      @(posedge core_clk);
      td_wr <= 1'b0;
   endtask

   task automatic fire(input logic [NUM_CH-1:0] m, input logic hw);
      @(posedge core_clk);
      if (hw) hw_trig <= m;
      else cpu_trig <= m;
      @(posedge core_clk);
      hw_trig  <= '0;
      cpu_trig <= '0;
   endtask

   task automatic wait_wr(input int n);
      int k;
      k = 0;
      while (wq.size() < n && k < 2000) begin
         @(posedge core_clk);
         k++;
      end
      if (wq.size() < n) begin
         chk(wq.size(), n);
         report_and_stop();
      end
   endtask

   // ****************
   // Scenarios
   // ****************
   task automatic sc_boot();
      put_td(0, 32'h0000_0020, 32'h8000_0600, ctl(16'h0, 7'h0, 1'b0, 1'b0));
      boot_en  <= 1'b1;
      ch_stall <= 24'h1;
      tick(20);
      chk(wq.size(), 0);
      chk(ch_active[0], 1);
      ch_stall <= '0;
      wait_wr(1);
      chk(wq[0][39:8], 32'h8000_0600);
      chk(wq[0][7:0], 8'h20 ^ 8'h5a);
   endtask

   task automatic sc_fifo();
      wq.delete();
      done_cnt = 0;
      end_cnt = 0;
      put_td(1, 32'h0000_0010, 32'h8000_0040, ctl(16'd11, 7'h0, 1'b0, 1'b1));
      wr_hold <= 1'b1;
      fire(24'h2, 1'b0);
      tick(80);
      chk(wq.size(), 0);
      chk(ch_active[1], 1);
      wr_hold <= 1'b0;
      wait_wr(12);
      for (int k = 0; k < 12; k++) begin
         chk(wq[k], {32'h8000_0040 + k, (8'h10 + k[7:0]) ^ 8'h5a});
      end
      tick(4);
      chk(done_cnt, 1);
      chk(end_cnt, 1);
      chk(ch_active[1], 0);
   endtask

   task automatic sc_prio();
      wq.delete();
      ch_prio[2] <= 3'h5;
      ch_prio[3] <= 3'h1;
      put_td(2, 32'h0000_0060, 32'h8000_0100, ctl(16'h0, 7'h0, 1'b0, 1'b0));
      put_td(3, 32'h0000_0070, 32'h8000_0200, ctl(16'h0, 7'h0, 1'b0, 1'b0));
      fire(24'hc, 1'b1);
      wait_wr(2);
      chk(wq[0][39:8], 32'h8000_0200);
      chk(wq[1][39:8], 32'h8000_0100);
   endtask

   task automatic sc_tie(input logic rrd);
      wq.delete();
      rr_disable[5] <= rrd;
      put_td(4, 32'h0000_0030, 32'h8000_0300, ctl(16'h1, 7'h0, 1'b0, 1'b0));
      put_td(5, 32'h0000_0040, 32'h8000_0400, ctl(16'h1, 7'h0, 1'b0, 1'b0));
      fire(24'h30, 1'b0);
      wait_wr(4);
      if (rrd) begin
         chk(wq[0][18:16], 3'h4);
         chk(wq[1][18:16], 3'h4);
      end else begin
         chk(wq[1][18:16] ^ wq[0][18:16], 3'h7);
         chk(wq[2][18:16] ^ wq[1][18:16], 3'h7);
      end
      rr_disable[5] <= 1'b0;
   endtask

   task automatic sc_loop();
      int n;
      wq.delete();
      cpu_req  <= 1'b1;
      cpu_addr <= 32'h0000_0004;
      put_td(6, 32'h0000_0050, 32'h8000_0500, ctl(16'h0, 7'h6, 1'b1, 1'b0));
      chk(cpu_grant, 1);
      fire(24'h40, 1'b1);
      wait_wr(5);
      chk(wq[4][39:8], 32'h8000_0500);
      put_td(6, 32'h0000_0050, 32'h8000_0700, ctl(16'h0, 7'h6, 1'b1, 1'b0));
      wq.delete();
      wait_wr(6);
      chk(wq[5][39:8], 32'h8000_0700);
      ch_cancel[6] <= 1'b1;
      @(posedge core_clk);
      ch_cancel[6] <= 1'b0;
      tick(30);
      chk(ch_active[6], 0);
      n = wq.size();
      tick(20);
      chk(wq.size(), n);
      cpu_req <= 1'b0;
   endtask

   task automatic sc_fair();
      int n;
      wq.delete();
      n = 0;
      fairness_en <= 1'b1;
      ch_prio[7] <= 3'h2;
      ch_prio[8] <= 3'h7;
      put_td(7, 32'h0000_0080, 32'h8000_0800, ctl(16'h0, 7'h7, 1'b1, 1'b0));
      put_td(8, 32'h0000_0090, 32'h8000_0900, ctl(16'h0, 7'h8, 1'b1, 1'b0));
      fire(24'h180, 1'b0);
      wait_wr(140);
      foreach (wq[k]) if (wq[k][19:16] == 4'h9) n++;
      chk(n != 0, 1);
      ch_cancel <= 24'h180;
      @(posedge core_clk);
      ch_cancel <= '0;
   endtask

   initial begin
      reset       = 1'b1;
      fairness_en = 1'b0;
      boot_en     = 1'b0;
      ch_en       = '1;
      ch_stall    = '0;
      ch_cancel   = '0;
      rr_disable  = '0;
      ch_prio     = {NUM_CH{3'h4}};
      for (int k = 0; k < NUM_CH; k++) ch_first_td[k] = k[6:0];
      hw_trig     = '0;
      cpu_trig    = '0;
      td_wr       = 1'b0;
      td_wr_word  = '0;
      td_wr_data  = 32'h0;
      cpu_req     = 1'b0;
      cpu_addr    = 32'h0;
      wr_hold     = 1'b0;
      fail_count  = 0;
      compares    = 0;
      done_cnt    = 0;
      end_cnt     = 0;
      tick(2);
      reset <= 1'b0;
      sc_boot();
      sc_fifo();
      sc_prio();
      sc_tie(1'b0);
      sc_tie(1'b1);
      sc_loop();
      sc_fair();
      report_and_stop();
   end
endmodule
